// *** logic/dtc_pkg.sv ***
// Shared constants and types of the dual timer/counter block.
package dtc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the APB bus)
  // ---------------------------------------------------------------
  localparam int unsigned DTC_ADDR_W = 8;
  localparam logic [7:0] DTC_OFS_MODE = 8'h00;
  localparam logic [7:0] DTC_OFS_CTRL = 8'h04;
  localparam logic [7:0] DTC_OFS_LOW0 = 8'h08;
  localparam logic [7:0] DTC_OFS_HIGH0 = 8'h0c;
  localparam logic [7:0] DTC_OFS_LOW1 = 8'h10;
  localparam logic [7:0] DTC_OFS_HIGH1 = 8'h14;
  localparam logic [7:0] DTC_OFS_PCFG = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned DTC_CTRL_OVF1 = 7;
  localparam int unsigned DTC_CTRL_RUN1 = 6;
  localparam int unsigned DTC_CTRL_OVF0 = 5;
  localparam int unsigned DTC_CTRL_RUN0 = 4;
  localparam int unsigned DTC_PCFG_TOG0 = 0;
  localparam int unsigned DTC_PCFG_TOG1 = 1;
  localparam int unsigned DTC_PCFG_HALVE = 2;

  // ---------------------------------------------------------------
  // Values after reset and cycle counts
  // ---------------------------------------------------------------
  localparam logic [7:0] DTC_RST_BYTE = 8'h00;
  localparam logic DTC_RST_TOGGLE = 1'b1;
  localparam int unsigned DTC_CLK_PER_MC = 6;
  localparam int unsigned DTC_PRE_W = 5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  // One timer's half of the mode register.
  typedef struct packed {
    logic gate;
    logic cnt_sel;
    dtc_mode_t mode;
  } dtc_tmode_t;

  // Count bytes plus the overflow produced by one step.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic ovf;
  } dtc_cnt_t;

  // Shared count/toggle pad driven by the block.
  typedef struct packed {
    logic out;
    logic oe;
  } dtc_pad_t;

endpackage

// *** logic/dtc_top.sv ***
// Dual timer/counter with APB register access and toggle outputs.
//
// Overview of operation
// - Timer function adds one to the count each machine cycle of 6 clocks.
// - Machine cycle is 6 clocks, or 12 when clock halving is selected.
// - Counter function samples pin once per cycle, counts on high then low.
// - Incremented value shows in the count during the following machine cycle.
// - Edge recognition takes two machine cycles, limiting rate to clock/12 events.
// - Per timer a count select bit and a two-bit mode field.
// - Mode 0 counts 13 bits: high byte over low five bits.
// - Wrap of the active width from all ones sets the overflow flag.
// - Count only when run is 1 and gate is 0 or gate pin is 1.
// - Setting run starts from existing count without clearing the bytes.
// - Timer one gate sits at mode bit 7, timer zero gate at bit 3.
// - Mode 1 uses all 16 bits of high and low bytes.
// - Mode 2 low byte counts, reloads from high byte on overflow.
// - Timer one in mode 3 stops, as if its run bit were cleared.
// - Timer zero mode 3 low byte is an 8-bit counter with own controls.
// - Timer zero mode 3 high byte counts cycles, uses timer one run and flag.
// - Timer one then runs without flag, stopped by its own mode 3.
// - With toggle enabled, each overflow inverts that timer's count pin.
// - Toggle pin drives 1 until the first overflow after enabling.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module dtc_top #(
  parameter int unsigned MC_CLKS = dtc_pkg::DTC_CLK_PER_MC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dtc_pkg::DTC_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CNT_PIN0_IN,
  input wire logic CNT_PIN1_IN,
  input wire logic GATE_PIN0,
  input wire logic GATE_PIN1,
  input wire logic VEC_ACK0,
  input wire logic VEC_ACK1,
  output dtc_pkg::dtc_pad_t CNT_PAD0,
  output dtc_pkg::dtc_pad_t CNT_PAD1,
  output logic OVF_FLAG0,
  output logic OVF_FLAG1,
  output logic TMR1_OVF_PULSE,
  output logic MC_TICK
);
  import dtc_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The prescaler must hold twice the cycle length when halving is on.
  if (MC_CLKS < 2 || 2 * MC_CLKS > (1 << DTC_PRE_W)) begin : g_bad_mc
    $error("MC_CLKS out of range for the prescaler width");
  end

  localparam logic [DTC_PRE_W-1:0] PRE_LAST = DTC_PRE_W'(MC_CLKS - 1);
  localparam logic [DTC_PRE_W-1:0] PRE_LAST_SLOW = DTC_PRE_W'(2 * MC_CLKS - 1);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Eight-bit increment returning the carry in the top bit.
  function automatic logic [8:0] dtc_inc8(input logic [7:0] v);
    dtc_inc8 = {1'b0, v} + 9'h001;
  endfunction

  // One count step of a timer in the given mode.
  function automatic dtc_cnt_t dtc_step(input dtc_cnt_t cur, input dtc_mode_t mode,
                                        input logic inc);
    dtc_cnt_t r;
    logic [5:0] s6;
    logic [8:0] s9;
    logic [16:0] s17;
    r = cur;
    r.ovf = 1'b0;
    s6 = {1'b0, cur.low[4:0]} + 6'h01;
    s9 = dtc_inc8(cur.low);
    s17 = {1'b0, cur.high, cur.low} + 17'h00001;
    if (inc) begin
      unique case (mode)
        DTC_MODE_13BIT: begin
          // Upper three low bits are left alone; software ignores them.
          r.low[4:0] = s6[4:0];
          if (s6[5]) begin
            {r.ovf, r.high} = dtc_inc8(cur.high);
          end
        end
        DTC_MODE_16BIT: begin
          {r.ovf, r.high, r.low} = s17;
        end
        DTC_MODE_RELOAD: begin
          r.ovf = s9[8];
          r.low = s9[8] ? cur.high : s9[7:0];
        end
        DTC_MODE_SPLIT: begin
          {r.ovf, r.low} = s9;
        end
      endcase
    end
    dtc_step = r;
  endfunction

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  dtc_tmode_t mode0_q, mode1_q;
  logic run0_q, run1_q, ovf0_q, ovf1_q;
  logic [7:0] low0_q, high0_q, low1_q, high1_q;
  logic tog_en0_q, tog_en1_q, halve_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [DTC_PRE_W-1:0] pre_q;
  logic tick;
  logic [1:0] cnt_meta_q, cnt_sync_q, gate_meta_q, gate_sync_q;
  logic [1:0] cnt_samp_q;
  logic [1:0] edge_det;
  logic tog0_q, tog1_q, t1_pulse_q;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic setup, wr, wr_lane0;
  logic hit_mode, hit_ctrl, hit_low0, hit_high0, hit_low1, hit_high1, hit_pcfg, hit_any;

  // Zero wait states: every access completes in its first access cycle.
  assign PREADY = 1'b1;
  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & PWRITE;
  assign wr_lane0 = wr & PSTRB[0];
  assign hit_mode = PADDR == DTC_OFS_MODE;
  assign hit_ctrl = PADDR == DTC_OFS_CTRL;
  assign hit_low0 = PADDR == DTC_OFS_LOW0;
  assign hit_high0 = PADDR == DTC_OFS_HIGH0;
  assign hit_low1 = PADDR == DTC_OFS_LOW1;
  assign hit_high1 = PADDR == DTC_OFS_HIGH1;
  assign hit_pcfg = PADDR == DTC_OFS_PCFG;
  assign hit_any = hit_mode | hit_ctrl | hit_low0 | hit_high0 | hit_low1 | hit_high1 | hit_pcfg;

  // Read data is captured in the setup cycle so it comes from a flop.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= ~hit_any;
      if (!PWRITE) begin
        unique case (1'b1)
          hit_mode: prdata_q[7:0] <= {mode1_q, mode0_q};
          hit_ctrl: prdata_q[7:4] <= {ovf1_q, run1_q, ovf0_q, run0_q};
          hit_low0: prdata_q[7:0] <= low0_q;
          hit_high0: prdata_q[7:0] <= high0_q;
          hit_low1: prdata_q[7:0] <= low1_q;
          hit_high1: prdata_q[7:0] <= high1_q;
          hit_pcfg: prdata_q[2:0] <= {halve_q, tog_en1_q, tog_en0_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PSLVERR = slverr_q & PSEL & PENABLE;

  // ---------------------------------------------------------------
  // Machine cycle prescaler
  // ---------------------------------------------------------------
  // One tick per machine cycle; halving doubles the cycle length.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pre_q <= '0;
    end else if (tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + DTC_PRE_W'(1);
    end
  end

  // Compare with >= so that leaving halving past the short limit ends the
  // cycle at once instead of letting the prescaler run all the way round.
  assign tick = pre_q >= (halve_q ? PRE_LAST_SLOW : PRE_LAST);
  assign MC_TICK = tick;

  // ---------------------------------------------------------------
  // Pin synchronisers and falling edge detection
  // ---------------------------------------------------------------
  // Two flops before any logic looks at a pin.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_meta_q <= 2'b00;
      cnt_sync_q <= 2'b00;
      gate_meta_q <= 2'b00;
      gate_sync_q <= 2'b00;
    end else begin
      cnt_meta_q <= {CNT_PIN1_IN, CNT_PIN0_IN};
      cnt_sync_q <= cnt_meta_q;
      gate_meta_q <= {GATE_PIN1, GATE_PIN0};
      gate_sync_q <= gate_meta_q;
    end
  end

  // Pin level is sampled once per machine cycle; a high sample followed
  // by a low one is an edge, so recognising one needs two cycles.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_samp_q <= 2'b00;
    end else if (tick) begin
      cnt_samp_q <= cnt_sync_q;
    end
  end

  assign edge_det = {2{tick}} & cnt_samp_q & ~cnt_sync_q;

  // ---------------------------------------------------------------
  // Count enables and next values
  // ---------------------------------------------------------------
  logic split0, stop1, en0, en1, inc0, inc1, inc0_high;
  logic ovf0_set, ovf1_set, wrap1;
  logic [8:0] high0_split;
  dtc_cnt_t res0, res1;

  assign split0 = mode0_q.mode == DTC_MODE_SPLIT;
  assign stop1 = mode1_q.mode == DTC_MODE_SPLIT;
  assign en0 = run0_q & (~mode0_q.gate | gate_sync_q[0]);
  assign en1 = run1_q & (~mode1_q.gate | gate_sync_q[1]) & ~stop1;
  // An edge counts at the tick that detects it, so the new value shows
  // during the next machine cycle.
  assign inc0 = en0 & (mode0_q.cnt_sel ? edge_det[0] : tick);
  assign inc1 = en1 & (mode1_q.cnt_sel ? edge_det[1] : tick);
  // The split high byte counts cycles only, started by timer one's run bit.
  assign inc0_high = split0 & run1_q & tick;
  assign high0_split = inc0_high ? dtc_inc8(high0_q) : {1'b0, high0_q};

  // Run bits only gate the step; the count bytes are never cleared.
  always_comb begin
    res0 = dtc_step({high0_q, low0_q, 1'b0}, mode0_q.mode, inc0);
    if (split0) begin
      res0.high = high0_split[7:0];
    end
    res1 = dtc_step({high1_q, low1_q, 1'b0}, mode1_q.mode, inc1);
  end

  assign wrap1 = res1.ovf;
  assign ovf0_set = res0.ovf;
  // In split mode timer one loses its flag to timer zero's high byte.
  assign ovf1_set = split0 ? high0_split[8] : wrap1;

  // ---------------------------------------------------------------
  // Count bytes: a bus write overrides the step in that cycle
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      low0_q <= DTC_RST_BYTE;
      high0_q <= DTC_RST_BYTE;
      low1_q <= DTC_RST_BYTE;
      high1_q <= DTC_RST_BYTE;
    end else begin
      low0_q <= (wr_lane0 && hit_low0) ? PWDATA[7:0] : res0.low;
      high0_q <= (wr_lane0 && hit_high0) ? PWDATA[7:0] : res0.high;
      low1_q <= (wr_lane0 && hit_low1) ? PWDATA[7:0] : res1.low;
      high1_q <= (wr_lane0 && hit_high1) ? PWDATA[7:0] : res1.high;
    end
  end

  // ---------------------------------------------------------------
  // Mode and port configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode0_q <= '0;
      mode1_q <= '0;
    end else if (wr_lane0 && hit_mode) begin
      mode1_q <= PWDATA[7:4];
      mode0_q <= PWDATA[3:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tog_en0_q <= 1'b0;
      tog_en1_q <= 1'b0;
      halve_q <= 1'b0;
    end else if (wr_lane0 && hit_pcfg) begin
      tog_en0_q <= PWDATA[DTC_PCFG_TOG0];
      tog_en1_q <= PWDATA[DTC_PCFG_TOG1];
      halve_q <= PWDATA[DTC_PCFG_HALVE];
    end
  end

  // ---------------------------------------------------------------
  // Control register: run bits and sticky overflow flags
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run0_q <= 1'b0;
      run1_q <= 1'b0;
    end else if (wr_lane0 && hit_ctrl) begin
      run0_q <= PWDATA[DTC_CTRL_RUN0];
      run1_q <= PWDATA[DTC_CTRL_RUN1];
    end
  end

  // A hardware set in the same cycle as a clear wins, so no wrap is lost.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ovf0_q <= 1'b0;
      ovf1_q <= 1'b0;
    end else begin
      if (ovf0_set) begin
        ovf0_q <= 1'b1;
      end else if (VEC_ACK0) begin
        ovf0_q <= 1'b0;
      end else if (wr_lane0 && hit_ctrl) begin
        ovf0_q <= PWDATA[DTC_CTRL_OVF0];
      end
      if (ovf1_set) begin
        ovf1_q <= 1'b1;
      end else if (VEC_ACK1) begin
        ovf1_q <= 1'b0;
      end else if (wr_lane0 && hit_ctrl) begin
        ovf1_q <= PWDATA[DTC_CTRL_OVF1];
      end
    end
  end

  assign OVF_FLAG0 = ovf0_q;
  assign OVF_FLAG1 = ovf1_q;

  // ---------------------------------------------------------------
  // Overflow toggle outputs
  // ---------------------------------------------------------------
  // While toggling is off the level is held at 1, so it starts high
  // whenever the feature is turned on.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tog0_q <= DTC_RST_TOGGLE;
      tog1_q <= DTC_RST_TOGGLE;
    end else begin
      if (!tog_en0_q) begin
        tog0_q <= DTC_RST_TOGGLE;
      end else if (res0.ovf) begin
        tog0_q <= ~tog0_q;
      end
      if (!tog_en1_q) begin
        tog1_q <= DTC_RST_TOGGLE;
      end else if (wrap1) begin
        tog1_q <= ~tog1_q;
      end
    end
  end

  // The pad doubles as count input; it is only driven while toggling.
  assign CNT_PAD0 = '{out: tog0_q, oe: tog_en0_q};
  assign CNT_PAD1 = '{out: tog1_q, oe: tog_en1_q};

  // ---------------------------------------------------------------
  // Timer one wrap pulse for a baud rate consumer
  // ---------------------------------------------------------------
  // Timer one keeps wrapping in split mode even though it sets no flag.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t1_pulse_q <= 1'b0;
    end else begin
      t1_pulse_q <= wrap1;
    end
  end

  assign TMR1_OVF_PULSE = t1_pulse_q;

endmodule

// *** verification/dtc_top_properties.sv ***
// Port-level assertions for the dual timer/counter block.
`timescale 1ns/10ps
module dtc_top_props #(
  parameter int unsigned MC_CLKS = dtc_pkg::DTC_CLK_PER_MC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dtc_pkg::DTC_ADDR_W-1:0] PADDR,
  input wire logic [3:0] PSTRB,
  input wire logic PSLVERR,
  input wire logic VEC_ACK0,
  input wire logic VEC_ACK1,
  input dtc_pkg::dtc_pad_t CNT_PAD0,
  input wire logic OVF_FLAG0,
  input wire logic OVF_FLAG1,
  input wire logic TMR1_OVF_PULSE,
  input wire logic MC_TICK
);
  import dtc_pkg::*;
  localparam int TMAX = 2 * MC_CLKS;
  logic ctrl_wr;
  // --------
  // Helpers
  // --------
  // A control write may move a flag either way, so it is excused below.
  assign ctrl_wr = PSEL && PENABLE && PWRITE && PSTRB[0] && (PADDR == DTC_OFS_CTRL);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_quiet;
    !MC_TICK [*5];
  endsequence
  // -----------
  // Properties
  // -----------
  property p_tick_gap;
    MC_TICK |=> s_quiet;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("machine tick too soon");
  property p_tick_due;
    MC_TICK |-> ##[1:TMAX] MC_TICK;
  endproperty
  a_tick_due: assert property (p_tick_due) else $error("machine tick too late");
  property p_set0;
    $rose(OVF_FLAG0) |-> $past(MC_TICK) || $past(ctrl_wr);
  endproperty
  a_set0: assert property (p_set0) else $error("flag zero set off a tick");
  property p_set1;
    $rose(OVF_FLAG1) |-> $past(MC_TICK) || $past(ctrl_wr);
  endproperty
  a_set1: assert property (p_set1) else $error("flag one set off a tick");
  property p_hold0;
    OVF_FLAG0 && !VEC_ACK0 && !ctrl_wr |=> OVF_FLAG0;
  endproperty
  a_hold0: assert property (p_hold0) else $error("flag zero dropped");
  property p_hold1;
    OVF_FLAG1 && !VEC_ACK1 && !ctrl_wr |=> OVF_FLAG1;
  endproperty
  a_hold1: assert property (p_hold1) else $error("flag one dropped");
  property p_tog;
    CNT_PAD0.oe && $past(CNT_PAD0.oe) && $changed(CNT_PAD0.out) |-> $past(MC_TICK);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle moved off a tick");
  property p_tog_idle;
    !CNT_PAD0.oe && !$past(CNT_PAD0.oe) |-> CNT_PAD0.out;
  endproperty
  a_tog_idle: assert property (p_tog_idle) else $error("idle toggle level low");
  property p_pulse;
    TMR1_OVF_PULSE |-> $past(MC_TICK) && !$past(TMR1_OVF_PULSE);
  endproperty
  a_pulse: assert property (p_pulse) else $error("timer one pulse misplaced");
  property p_err;
    PSLVERR |-> PSEL && PENABLE;
  endproperty
  a_err: assert property (p_err) else $error("slave error outside access");
endmodule

bind dtc_top dtc_top_props #(.MC_CLKS(MC_CLKS)) u_props (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PSTRB(PSTRB), .PSLVERR(PSLVERR),
  .VEC_ACK0(VEC_ACK0), .VEC_ACK1(VEC_ACK1), .CNT_PAD0(CNT_PAD0), .OVF_FLAG0(OVF_FLAG0),
  .OVF_FLAG1(OVF_FLAG1), .TMR1_OVF_PULSE(TMR1_OVF_PULSE), .MC_TICK(MC_TICK));

// *** verification/dtc_pin_model.sv ***
// Behavioural model of the event sources on the two count pins.
`timescale 1ns/10ps
module dtc_pin_model (
  input wire logic clk,
  input wire logic [1:0] run,
  input wire logic [3:0] hold,
  input dtc_pkg::dtc_pad_t pad0,
  input dtc_pkg::dtc_pad_t pad1,
  output logic pin0,
  output logic pin1,
  output logic [1:0][7:0] falls
);
  import dtc_pkg::*;
  logic [1:0] lvl = 2'b11;
  logic [1:0][3:0] cnt = '0;
  // The pin follows the block while it drives, else the source with a pull-up.
  assign pin0 = pad0.oe ? pad0.out : lvl[0];
  assign pin1 = pad1.oe ? pad1.out : lvl[1];
  // Each level stands hold+1 cycles, never under a machine cycle.
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (!run[i]) begin
        lvl[i] <= 1'b1;
        cnt[i] <= 4'h0;
        falls[i] <= 8'h00;
      end else if (cnt[i] == hold) begin
        lvl[i] <= !lvl[i];
        cnt[i] <= 4'h0;
        falls[i] <= falls[i] + {7'h00, lvl[i]};
      end else begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
endmodule

// *** verification/dual_timer_counter_tb.sv ***
// Self-checking bench for the dual timer/counter with a pad model.
`timescale 1ns/10ps
`define CHK(nm, ex, sv) begin \
  checks_done++; \
  if ((sv) !== (ex)) begin \
    num_errors++; \
    $display("FAIL %s expected %0h seen %0h", nm, ex, sv); \
  end \
end
module dual_timer_counter_tb;
  import dtc_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic [3:0] PSTRB = 4'hf;
  logic GATE_PIN0 = 1'b1;
  logic GATE_PIN1 = 1'b1;
  logic VEC_ACK0 = 1'b0;
  logic VEC_ACK1 = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, CNT_PIN0_IN, CNT_PIN1_IN, OVF_FLAG0, OVF_FLAG1, TMR1_OVF_PULSE, MC_TICK;
  dtc_pad_t CNT_PAD0, CNT_PAD1;
  logic [1:0] ev_run = 2'b00;
  logic [3:0] ev_hold = 4'h6;
  logic [1:0][7:0] falls;
  logic [31:0] seed = 32'hf115c61f;
  logic [31:0] rd;
  logic err;
  logic [7:0] j;
  logic [15:0] pv;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int k, n;

  dtc_top #(.MC_CLKS(6)) dut (.*);
  dtc_pin_model pins (.clk(CLK), .run(ev_run), .hold(ev_hold), .pad0(CNT_PAD0),
    .pad1(CNT_PAD1), .pin0(CNT_PIN0_IN), .pin1(CNT_PIN1_IN), .falls(falls));

  // ---------------
  // Clock and limits
  // ---------------
  initial begin
    forever #20 CLK = ~CLK;
  end
  // A hang is cut short well past the longest expected run.
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ---------------
  // Helpers
  // ---------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Preset that overflows after k steps; junk goes where the width ignores it.
  function automatic logic [15:0] preset(input int m, input int k, input logic [7:0] j);
    logic [15:0] v;
    v = 16'hffff - 16'(k - 1);
    case (m)
      0: preset = {v[12:5], j[7:5], v[4:0]};
      2: preset = {j, v[7:0]};
      default: preset = v;
    endcase
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Counts machine ticks until the chosen flag shows.
  task automatic wait_flag(input int f);
    n = 0;
    repeat (3000) begin
      @(negedge CLK);
      if ((f ? OVF_FLAG1 : OVF_FLAG0) === 1'b1) break;
      if (MC_TICK === 1'b1) n++;
    end
  endtask
  task automatic gap();
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (MC_TICK !== 1'b1);
  endtask
  task automatic ack();
    @(posedge CLK);
    VEC_ACK0 <= 1'b1;
    VEC_ACK1 <= 1'b1;
    @(posedge CLK);
    VEC_ACK0 <= 1'b0;
    VEC_ACK1 <= 1'b0;
    @(negedge CLK);
    `CHK("flags after ack", 2'b00, {OVF_FLAG1, OVF_FLAG0})
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------
  // Scenarios
  // ---------------
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    for (int a = 0; a <= 28; a += 4) begin
      apb(1'b0, 8'(a), 8'h00);
      `CHK("reset read", 32'h0, rd)
      `CHK("slave error", a == 28, err)
    end
    `CHK("pad idle", 4'ha, {CNT_PAD1, CNT_PAD0})
    j = 8'(rnd());
    apb(1'b1, DTC_OFS_MODE, j);
    apb(1'b0, DTC_OFS_MODE, 8'h00);
    `CHK("mode readback", {24'h0, j}, rd)
    $display("registers done");
    for (int m = 0; m < 3; m++) begin
      j = 8'(rnd());
      k = 1 + rnd() % (m == 2 ? 256 : 300);
      pv = preset(m, k, j);
      apb(1'b1, DTC_OFS_MODE, 8'(m));
      apb(1'b1, DTC_OFS_PCFG, 8'h01);
      apb(1'b1, DTC_OFS_LOW0, pv[7:0]);
      apb(1'b1, DTC_OFS_HIGH0, pv[15:8]);
      `CHK("pad before wrap", 1'b1, CNT_PAD0.out)
      apb(1'b1, DTC_OFS_CTRL, 8'h10);
      wait_flag(0);
      `CHK("ticks to wrap", k, n)
      `CHK("pad after wrap", 1'b0, CNT_PAD0.out)
      apb(1'b0, DTC_OFS_HIGH0, 8'h00);
      `CHK("high byte", m == 2 ? {24'h0, j} : 32'h0, rd)
      apb(1'b0, DTC_OFS_LOW0, 8'h00);
      `CHK("low byte", {24'h0, m == 2 ? j : m == 0 ? {j[7:5], 5'h00} : 8'h00}, rd)
      apb(1'b1, DTC_OFS_CTRL, 8'h20);
      @(negedge CLK);
      `CHK("flag held", 1'b1, OVF_FLAG0)
      ack();
      apb(1'b1, DTC_OFS_PCFG, 8'h00);
    end
    $display("timer modes done");
    k = 1 + rnd() % 8;
    pv = preset(1, k, 8'h00);
    apb(1'b1, DTC_OFS_MODE, 8'h50);
    apb(1'b1, DTC_OFS_LOW1, pv[7:0]);
    apb(1'b1, DTC_OFS_HIGH1, pv[15:8]);
    apb(1'b1, DTC_OFS_CTRL, 8'h40);
    ev_hold <= 4'(6 + rnd() % 9);
    ev_run <= 2'b10;
    wait_flag(1);
    `CHK("edges at wrap", 8'(k), falls[1])
    `CHK("wrap pulse", 1'b1, TMR1_OVF_PULSE)
    @(posedge CLK);
    ev_run <= 2'b00;
    apb(1'b1, DTC_OFS_CTRL, 8'h00);
    $display("counter done");
    pv = preset(1, 1, 8'h00);
    apb(1'b1, DTC_OFS_MODE, 8'h09);
    apb(1'b1, DTC_OFS_LOW0, pv[7:0]);
    apb(1'b1, DTC_OFS_HIGH0, pv[15:8]);
    GATE_PIN0 <= 1'b0;
    apb(1'b1, DTC_OFS_CTRL, 8'h10);
    repeat (60) @(negedge CLK);
    `CHK("gated closed", 1'b0, OVF_FLAG0)
    @(posedge CLK);
    GATE_PIN0 <= 1'b1;
    wait_flag(0);
    `CHK("gated open", 1'b1, OVF_FLAG0)
    apb(1'b1, DTC_OFS_CTRL, 8'h00);
    @(negedge CLK);
    `CHK("flag written zero", 1'b0, OVF_FLAG0)
    $display("gate done");
    k = 1 + rnd() % 200;
    pv = preset(2, k, 8'hff);
    apb(1'b1, DTC_OFS_MODE, 8'h33);
    apb(1'b1, DTC_OFS_HIGH0, pv[7:0]);
    apb(1'b1, DTC_OFS_LOW1, 8'hff);
    apb(1'b1, DTC_OFS_LOW0, 8'hff);
    apb(1'b1, DTC_OFS_CTRL, 8'h50);
    wait_flag(1);
    `CHK("split high ticks", k, n)
    `CHK("split low wrap", 1'b1, OVF_FLAG0)
    apb(1'b0, DTC_OFS_LOW1, 8'h00);
    `CHK("timer one stopped", 32'hff, rd)
    apb(1'b1, DTC_OFS_CTRL, 8'h00);
    ack();
    $display("split done");
    apb(1'b1, DTC_OFS_PCFG, 8'h04);
    repeat (3) gap();
    `CHK("halved cycle", 12, n)
    @(posedge CLK);
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, DTC_OFS_PCFG, 8'h00);
    `CHK("config after reset", 32'h0, rd)
    repeat (2) gap();
    `CHK("normal cycle", 6, n)
    $display("halving done");
    wrap_up();
  end
endmodule
